// >>> pkg/srw_link_if.sv
// Four shared pins between the device and the external serial host.
// Assumes each end drives only its own pins; undriven pins pull high.
`timescale 1ns/10ps
interface srw_link_if;
  logic [3:0] dev_out;
  logic [3:0] dev_oe;
  logic [3:0] host_out;
  logic [3:0] host_oe;
  logic [3:0] pin;

  // ==========================================================
  // Wire resolution with pull-ups
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      assign pin[gi] = dev_oe[gi] ? dev_out[gi] : (host_oe[gi] ? host_out[gi] : 1'b1);
    end
  endgenerate

  modport dev  (output dev_out, output dev_oe, input pin);
  modport host (output host_out, output host_oe, input pin);
endinterface

// >>> pkg/srw_pkg.sv
// Constants and types shared by the serial register window port ends.
// Assumes a 20 MHz system clock on both ends and a host-made link clock.
//
// Behaviour
// - Mode bit turns four pins into serial port
// - Serial port reaches only four general words
// - Host never writes general word zero serially (the code writes it at addresses 0 to 3)
// - Shared pins stay pulled-up inputs until enabled
// - Serial mode overrides the pin direction bits
// - Host serial clock at most 2.5 MHz
// - Sixteen byte window, most significant byte first
// - Host moves whole words, several allowed
// - Read: select low, send 03h MSB first
// - Read data MSB first, out on fall, sampled rising
// - Byte address advances after every byte
// - Upper address nibble ignored, address wraps 15 to 0
// - Write: 02h, start address, then data bytes
// - Select rises only after last data bit
// - EEPROM mode loads unit words after reset
package srw_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int SCK_MAX_HZ   = 2_500_000;
  localparam int SCK_HALF_CYC = (CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);

  // ==========================================================
  // Serial window
  localparam int          NUM_WORDS   = 4;
  localparam int          FRAME_BITS  = 48;
  localparam logic [7:0]  CMD_READ    = 8'h03;
  localparam logic [7:0]  CMD_WRITE   = 8'h02;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam int          PIN_SCK     = 0;
  localparam int          PIN_SEL     = 1;
  localparam int          PIN_SDI     = 2;
  localparam int          PIN_SDO     = 3;
  localparam logic [3:0]  DEV_OE_SER  = 4'h8;
  localparam logic [3:0]  HOST_OE     = 4'h7;

  // ==========================================================
  // Host controller registers
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_WDATA      = 8'h04;
  localparam logic [7:0] OFS_RDATA      = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h0c;
  localparam int         CTRL_START_BIT = 0;
  localparam int         CTRL_WRITE_BIT = 1;
  localparam int         CTRL_ADDR_LSB  = 8;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ==========================================================
  // State machines
  typedef enum logic [1:0] {
    DS_CMD  = 2'h0,
    DS_ADDR = 2'h1,
    DS_DATA = 2'h3,
    DS_SKIP = 2'h2
  } srw_dev_state_type;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_RUN  = 2'h1,
    HS_DONE = 2'h3
  } srw_host_state_type;

endpackage

// >>> test/srw_link_sva.sv
// Checker for the serial window link: frame shape and pin timing.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/10ps
module srw_link_sva
  import srw_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC
)
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       serial_host_mode,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] host_out,
  input wire logic [3:0] pin
);
  localparam int FR_MIN = 2 * HALF_CYC * FRAME_BITS - 8;
  localparam int FR_MAX = 2 * HALF_CYC * FRAME_BITS + 8;
  logic       sck_q_r;
  logic [7:0] rise_cnt_r;
  logic [7:0] hold_cnt_r;
  wire        sck_w   = host_out[PIN_SCK];
  wire        sel_w   = host_out[PIN_SEL];
  wire        sck_chg = sck_w != sck_q_r;

  // ==========================================================
  // Helper counters
  always_ff @(posedge aclk)
  begin
    sck_q_r    <= sck_w;
    rise_cnt_r <= (!aresetn || sel_w) ? 8'h00 : rise_cnt_r + {7'h0, sck_w & ~sck_q_r};
    hold_cnt_r <= (!aresetn || sck_chg) ? 8'h00 : hold_cnt_r + {7'h0, hold_cnt_r != 8'hff};
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Mode is registered inside, so allow a few cycles to settle
  chk_ser_oe_sdo: assert property (
    serial_host_mode [*4] |-> dev_oe == DEV_OE_SER) else $error("serial pin drive wrong");
  chk_reset_oe_off: assert property (
    $rose(aresetn) |-> dev_oe == 4'h0) else $error("pins driven after reset");
  chk_frame_bits: assert property (
    $rose(sel_w) |-> rise_cnt_r == FRAME_BITS) else $error("frame clock count wrong");
  chk_frame_time: assert property (
    $fell(sel_w) |-> ##[FR_MIN:FR_MAX] $rose(sel_w)) else $error("frame length wrong");
  chk_sck_half: assert property (
    !sel_w && sck_chg |-> hold_cnt_r >= HALF_CYC - 1) else $error("serial clock too fast");
  chk_sdo_on_low: assert property (
    serial_host_mode && !pin[PIN_SEL] && $changed(dev_out[PIN_SDO]) |-> !$past(pin[PIN_SCK]))
    else $error("serial out moved in high phase");
  chk_sdi_on_low: assert property (
    !sel_w && $changed(host_out[PIN_SDI]) |-> !sck_w) else $error("serial in moved in high phase");
  chk_sck_idle_low: assert property (
    sel_w |-> !sck_w) else $error("serial clock runs outside frame");

  cover property ($rose(sel_w));
  cover property (serial_host_mode && !pin[PIN_SEL] && $changed(dev_out[PIN_SDO]));
  cover property ($rose(serial_host_mode));
endmodule

// >>> test/testbench.sv
// Bench joining device and host ends over the link interface.
// Assumes software access through the host's AXI4-Lite registers.
`timescale 1ns/10ps
module testbench
  import srw_pkg::*;
;
  logic                aclk;
  logic                aresetn;
  logic                serial_host_mode, eeprom_mode_select, unit_id_valid, unit_id_pending;
  logic [3:0]          pin_direction_cfg, gp_out, gp_in, s_axi_wstrb;
  logic [127:0]        unit_id_data;
  logic                net_wr_en;
  logic [1:0]          net_wr_idx, s_axi_bresp, s_axi_rresp;
  logic [31:0]         net_wr_data, s_axi_wdata, s_axi_rdata;
  logic [3:0][31:0]    general_word;
  logic [7:0]          s_axi_awaddr, s_axi_araddr;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int                  error_cnt = 0;
  int                  samples_checked = 0;
  int                  cyc = 0;

  srw_link_if lnk();
  srw_dev i_srw_dev (.aclk, .aresetn, .clk_en(1'b1), .link(lnk.dev), .serial_host_mode,
    .pin_direction_cfg, .gp_out, .gp_in, .eeprom_mode_select, .unit_id_valid, .unit_id_data,
    .net_wr_en, .net_wr_idx, .net_wr_data, .general_word, .unit_id_pending);
  srw_host #(.HALF_CYC(SCK_HALF_CYC)) i_srw_host (.aclk, .aresetn, .clk_en(1'b1),
    .link(lnk.host), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  srw_link_sva #(.HALF_CYC(SCK_HALF_CYC)) i_srw_link_sva (.aclk, .aresetn, .serial_host_mode,
    .dev_out(lnk.dev_out), .dev_oe(lnk.dev_oe), .host_out(lnk.host_out), .pin(lnk.pin));

  // ==========================================================
  // Clock and hang guard
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Nine frames of about 400 cycles fit well inside this
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Readies and answers are read at the falling edge, where they are settled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       aw_p;
    logic       w_p;
    logic       aw_hs;
    logic       w_hs;
    logic [1:0] resp;
    aw_p = 1'b1;
    w_p  = 1'b1;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (aw_p || w_p)
    begin
      @(negedge aclk);
      aw_hs = aw_p && s_axi_awready;
      w_hs  = w_p && s_axi_wready;
      @(posedge aclk);
      if (aw_hs)
      begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_hs)
      begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do
      @(negedge aclk);
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk({30'h0, resp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic [1:0] resp;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
      @(negedge aclk);
    while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do
      @(negedge aclk);
    while (!s_axi_rvalid);
    d    = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk({30'h0, resp}, {30'h0, er});
  endtask

  // One whole-word frame, then the last received word
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    logic [31:0] st;
    st = 32'h1;
    axi_wr(OFS_WDATA, wd, RESP_OKAY);
    axi_wr(OFS_CTRL, {16'h0, a, 6'h0, wr, 1'b1}, RESP_OKAY);
    while (st[0])
      axi_rd(OFS_STATUS, RESP_OKAY, st);
    axi_rd(OFS_RDATA, RESP_OKAY, rd);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_idle();
    logic [31:0] d;
    chk({28'h0, gp_in}, 32'ha);
    chk(general_word[0], WORD_RST);
    chk({31'h0, unit_id_pending}, 32'h0);
    axi_rd(8'h10, RESP_SLVERR, d);
    chk(d, 32'h0);
    axi_wr(8'h10, 32'h1, RESP_SLVERR);
    $display("test idle done");
  endtask

  task automatic t_general();
    pin_direction_cfg <= 4'h8;
    repeat (6) @(posedge aclk);
    chk({28'h0, gp_in}, 32'h2);
    pin_direction_cfg <= 4'h0;
    repeat (6) @(posedge aclk);
    chk({28'h0, gp_in}, 32'ha);
    $display("test general done");
  endtask

  task automatic t_mode_off();
    logic [31:0] d;
    xfer(1'b1, 8'h04, 32'h1111_1111, d);
    chk(general_word[1], WORD_RST);
    xfer(1'b0, 8'h04, 32'h0, d);
    chk(d, 32'hffff_ffff);
    $display("test mode off done");
  endtask

  task automatic t_serial_rw();
    logic [31:0] d;
    serial_host_mode  <= 1'b1;
    pin_direction_cfg <= 4'hf;
    repeat (6) @(posedge aclk);
    xfer(1'b1, 8'h04, 32'h1234_5678, d);
    chk(general_word[1], 32'h1234_5678);
    xfer(1'b1, 8'hf8, 32'h9abc_def0, d);
    chk(general_word[2], 32'h9abc_def0);
    xfer(1'b0, 8'h04, 32'h0, d);
    chk(d, 32'h1234_5678);
    xfer(1'b0, 8'h08, 32'h0, d);
    chk(d, 32'h9abc_def0);
    chk({28'h0, lnk.dev_oe}, {28'h0, DEV_OE_SER});
    $display("test serial done");
  endtask

  task automatic t_wrap();
    logic [31:0] d;
    net_wr_en   <= 1'b1;
    net_wr_idx  <= 2'h3;
    net_wr_data <= 32'h0102_0304;
    @(posedge aclk);
    net_wr_en <= 1'b0;
    @(posedge aclk);
    chk(general_word[3], 32'h0102_0304);
    // Whole aligned word only, so word zero is not reached by this frame
    xfer(1'b1, 8'hfc, 32'haabb_ccdd, d);
    chk(general_word[3], 32'haabb_ccdd);
    chk(general_word[0], WORD_RST);
    xfer(1'b0, 8'hfc, 32'h0, d);
    chk(d, 32'haabb_ccdd);
    $display("test wrap done");
  endtask

  task automatic t_eeprom();
    logic [31:0] d;
    int          n;
    n = 0;
    eeprom_mode_select <= 1'b1;
    unit_id_valid      <= 1'b1;
    unit_id_data       <= {32'h4444_0004, 32'h3333_0003, 32'h2222_0002, 32'h1111_0001};
    aresetn            <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    while (unit_id_pending && n < 50)
    begin
      @(posedge aclk);
      n++;
    end
    chk(general_word[0], 32'h1111_0001);
    chk(general_word[3], 32'h4444_0004);
    repeat (6) @(posedge aclk);
    xfer(1'b0, 8'h0c, 32'h0, d);
    chk(d, 32'h4444_0004);
    $display("test eeprom done");
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    aresetn = 1'b0;
    {serial_host_mode, eeprom_mode_select, unit_id_valid, net_wr_en} = 4'h0;
    {pin_direction_cfg, gp_out, net_wr_idx, net_wr_data, unit_id_data} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    t_idle();
    t_general();
    t_mode_off();
    t_serial_rw();
    t_wrap();
    t_eeprom();
    complete_run();
  end
endmodule

// >>> verilog/srw_dev.sv
// Device end: general pins, four general words and the serial window.
// Assumes the link pins arrive asynchronously and are resynchronised here.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module srw_dev
  import srw_pkg::*;
#(
  parameter int NW = NUM_WORDS
)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 clk_en,
  srw_link_if.dev                   link,
  input  wire logic                 serial_host_mode,
  input  wire logic [3:0]           pin_direction_cfg,
  input  wire logic [3:0]           gp_out,
  output logic      [3:0]           gp_in,
  input  wire logic                 eeprom_mode_select,
  input  wire logic                 unit_id_valid,
  input  wire logic [NW*32-1:0]     unit_id_data,
  input  wire logic                 net_wr_en,
  input  wire logic [1:0]           net_wr_idx,
  input  wire logic [31:0]          net_wr_data,
  output logic [NW-1:0][31:0]       general_word,
  output logic                      unit_id_pending
);

  // ==========================================================
  // Elaboration check
  if (NW != 4)
  begin : g_chk
    $error("srw_dev serves exactly four words");
  end

  // ==========================================================
  // Byte lane of a window address
  function automatic logic [4:0] lane_lsb(input logic [3:0] a);
    lane_lsb = {2'h3 - a[1:0], 3'h0};
  endfunction

  // ==========================================================
  // Synchronisers
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic       sck_d_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Idle levels: the link clock rests low, so no false edge after reset
      sync1_r <= 5'h1e;
      sync2_r <= 5'h1e;
      sck_d_r <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_r <= {eeprom_mode_select, link.pin};
      sync2_r <= sync1_r;
      sck_d_r <= sync2_r[PIN_SCK];
    end
  end

  wire logic [3:0] pin_s   = sync2_r[3:0];
  wire logic       eep_s   = sync2_r[4];
  wire logic       sck_s   = pin_s[PIN_SCK];
  wire logic       sel_hi  = pin_s[PIN_SEL];
  wire logic       sdi_s   = pin_s[PIN_SDI];

  // ==========================================================
  // Mode and pin drive
  logic       mode_r;
  logic [3:0] oe_r;
  logic [3:0] out_r;
  logic [7:0] tx_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_r <= 1'b0;
      oe_r   <= 4'h0;
      out_r  <= 4'h0;
    end
    else if (clk_en)
    begin
      mode_r <= serial_host_mode;
      // Raw mode bit here, so the direction bits never leak for one cycle
      oe_r   <= serial_host_mode ? DEV_OE_SER : pin_direction_cfg;
      out_r  <= serial_host_mode ? {tx_r[7], 3'h0} : gp_out;
    end
  end

  assign link.dev_oe  = oe_r;
  assign link.dev_out = out_r;
  assign gp_in        = pin_s;

  // ==========================================================
  // Serial receive side
  // Edges come from the synchronised copy, so the link clock must stay
  // well below the system clock; 2.5 MHz leaves four cycles per phase.
  wire logic active   = mode_r && !sel_hi;
  wire logic sck_rise = active && sck_s && !sck_d_r;
  wire logic sck_fall = active && !sck_s && sck_d_r;

  srw_dev_state_type state_r;
  logic [2:0]        bit_r;
  logic [6:0]        rx_r;
  logic [3:0]        addr_r;
  logic              is_wr_r;

  wire logic       byte_done = sck_rise && (bit_r == 3'h7);
  wire logic [7:0] byte_rx   = {rx_r, sdi_s};
  wire logic       ser_wr    = byte_done && (state_r == DS_DATA) && is_wr_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bit_r <= 3'h0;
      rx_r  <= 7'h00;
    end
    else if (clk_en)
    begin
      if (sel_hi)
      begin
        bit_r <= 3'h0;
      end
      else if (sck_rise)
      begin
        bit_r <= bit_r + 3'h1;
        rx_r  <= byte_rx[6:0];
      end
    end
  end

  srw_dev_state_type state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      DS_CMD:
      begin
        if (byte_rx == CMD_READ || byte_rx == CMD_WRITE)
        begin
          state_nxt = DS_ADDR;
        end
        else
        begin
          state_nxt = DS_SKIP;
        end
      end
      DS_ADDR: state_nxt = DS_DATA;
      DS_DATA: state_nxt = DS_DATA;
      DS_SKIP: state_nxt = DS_SKIP;
      default: state_nxt = DS_CMD;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= DS_CMD;
      is_wr_r <= 1'b0;
      addr_r  <= 4'h0;
    end
    else if (clk_en)
    begin
      if (sel_hi)
      begin
        state_r <= DS_CMD;
      end
      else if (byte_done)
      begin
        state_r <= state_nxt;
        if (state_r == DS_CMD)
        begin
          is_wr_r <= (byte_rx == CMD_WRITE);
        end
        if (state_r == DS_ADDR)
        begin
          addr_r <= byte_rx[3:0];
        end
        if (state_r == DS_DATA)
        begin
          addr_r <= addr_r + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // General words
  logic [NW-1:0][31:0] word_r;
  logic                pend_r;

  wire logic [1:0] ser_idx  = addr_r[3:2];
  wire logic [4:0] ser_lane = lane_lsb(addr_r);
  wire logic       do_load  = pend_r && eep_s && unit_id_valid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_r <= 1'b1;
    end
    else if (clk_en && (do_load || !eep_s))
    begin
      pend_r <= 1'b0;
    end
  end

  // Load beats serial, serial beats the network side in a shared cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      word_r <= {NW{WORD_RST}};
    end
    else if (clk_en)
    begin
      if (do_load)
      begin
        word_r <= unit_id_data;
      end
      else if (ser_wr)
      begin
        word_r[ser_idx][ser_lane +: 8] <= byte_rx;
      end
      else if (net_wr_en)
      begin
        word_r[net_wr_idx] <= net_wr_data;
      end
    end
  end

  assign general_word    = word_r;
  assign unit_id_pending = pend_r;

  // ==========================================================
  // Serial transmit side
  // The byte is fetched on the first falling edge of each data byte,
  // so an address that advanced on the last rising edge is already used.
  wire logic       rd_data = (state_r == DS_DATA) && !is_wr_r;
  wire logic [7:0] rd_byte = word_r[ser_idx][ser_lane +: 8];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_r <= 8'h00;
    end
    else if (clk_en)
    begin
      if (sel_hi)
      begin
        tx_r <= 8'h00;
      end
      else if (sck_fall)
      begin
        tx_r <= (rd_data && bit_r == 3'h0) ? rd_byte : {tx_r[6:0], 1'b0};
      end
    end
  end

endmodule

// >>> verilog/srw_host.sv
// Host end: AXI4-Lite controlled master of the serial window link.
// Assumes software starts one word transfer at a time and polls busy.
`timescale 1ns/10ps
module srw_host
  import srw_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  srw_link_if.host         link,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ==========================================================
  // Elaboration check
  if (HALF_CYC < SCK_HALF_CYC || HALF_CYC > 256)
  begin : g_chk
    $error("srw_host link clock too fast");
  end

  // ==========================================================
  // AXI4-Lite slave
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_hold_r;
  logic        aw_full_r;
  logic        w_full_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  assign s_axi_awready = clk_en && !aw_full_r && !bvalid_r;
  assign s_axi_wready  = clk_en && !w_full_r && !bvalid_r;
  assign s_axi_arready = clk_en && !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  wire logic do_wr    = clk_en && aw_full_r && w_full_r;
  wire logic wr_map   = awaddr_r == OFS_CTRL || awaddr_r == OFS_WDATA;
  wire logic wr_ctrl  = do_wr && awaddr_r == OFS_CTRL && s_axi_wstrb != 4'h0;
  wire logic wr_wdata = do_wr && awaddr_r == OFS_WDATA;
  wire logic rd_take  = s_axi_arvalid && s_axi_arready;
  wire logic rd_map   = s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_hold_r <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_r     <= 1'b1;
        wdata_hold_r <= s_axi_wdata;
      end
      if (do_wr)
      begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Controller registers and link sequencer
  srw_host_state_type state_r;
  logic [31:0]        wdata_r;
  logic [31:0]        rx_r;
  logic [31:0]        result_r;
  logic [FRAME_BITS-1:0] tx_r;
  logic [5:0]         bits_r;
  logic [7:0]         half_r;
  logic               sck_r;
  logic               sel_r;
  logic [1:0]         sdo_sync_r;

  wire logic busy  = state_r != HS_IDLE;
  wire logic start = wr_ctrl && wdata_hold_r[CTRL_START_BIT] && !busy;
  wire logic tick  = half_r == 8'h00;
  wire logic is_wr = wdata_hold_r[CTRL_WRITE_BIT];
  wire logic [7:0] cmd = is_wr ? CMD_WRITE : CMD_READ;
  wire logic [31:0] rd_val =
    (s_axi_araddr == OFS_WDATA)  ? wdata_r :
    (s_axi_araddr == OFS_RDATA)  ? result_r :
    (s_axi_araddr == OFS_STATUS) ? {31'h0, busy} : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (rd_take)
      begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_map ? rd_val : 32'h0000_0000;
        rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        rvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sdo_sync_r <= 2'h3;
      wdata_r    <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      sdo_sync_r <= {sdo_sync_r[0], link.pin[PIN_SDO]};
      if (wr_wdata)
      begin
        wdata_r <= wdata_hold_r;
      end
    end
  end

  // Data is sampled late in the high phase so the device's resync delay
  // is covered; the pin value is then the one present at the rising edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r  <= HS_IDLE;
      sck_r    <= 1'b0;
      sel_r    <= 1'b1;
      tx_r     <= '0;
      rx_r     <= 32'h0000_0000;
      result_r <= 32'h0000_0000;
      bits_r   <= 6'h00;
      half_r   <= 8'h00;
    end
    else if (clk_en)
    begin
      case (state_r)
        HS_IDLE:
        begin
          if (start)
          begin
            tx_r    <= {cmd, wdata_hold_r[CTRL_ADDR_LSB +: 8], is_wr ? wdata_r : 32'h0};
            sel_r   <= 1'b0;
            bits_r  <= 6'h00;
            half_r  <= 8'(HALF_CYC - 1);
            state_r <= HS_RUN;
          end
        end
        HS_RUN:
        begin
          half_r <= tick ? 8'(HALF_CYC - 1) : half_r - 8'h01;
          if (tick && !sck_r)
          begin
            sck_r  <= 1'b1;
            bits_r <= bits_r + 6'h01;
          end
          else if (tick)
          begin
            sck_r <= 1'b0;
            rx_r  <= {rx_r[30:0], sdo_sync_r[1]};
            tx_r  <= {tx_r[FRAME_BITS-2:0], 1'b0};
            if (bits_r == 6'(FRAME_BITS))
            begin
              state_r <= HS_DONE;
            end
          end
        end
        HS_DONE:
        begin
          sel_r    <= 1'b1;
          result_r <= rx_r;
          state_r  <= HS_IDLE;
        end
        default: state_r <= HS_IDLE;
      endcase
    end
  end

  assign link.host_oe  = HOST_OE;
  assign link.host_out = {1'b0, tx_r[FRAME_BITS-1], sel_r, sck_r};

endmodule
